// *** src/led_sink_pkg.sv ***
// Purpose: Shared constants for the LED sink control block
// Assumes: 50 MHz system clock
// Notes: Register offsets are byte addresses on AXI4-Lite
package led_sink_pkg;
   localparam int CHANNELS = 16;
   localparam int DC_BITS = 6;
   localparam int GS_BITS = 12;
   localparam int GS_LEN = 192;
   localparam int DC_LEN = 96;
   localparam int SID_TEF_POS = 16;
   localparam int SID_DC_LO = 24;
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_NS = 20;
   localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAX_STAGGER_NS = 300;
   localparam int OPEN_DETECT_NS = 1000;
   localparam int OPEN_DETECT_CYC =
      (OPEN_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_OPEN = 8'h08;
   localparam logic [7:0] REG_GSCOUNT = 8'h0c;
   localparam logic [7:0] REG_ID = 8'h10;
   localparam logic [31:0] ID_VALUE = 32'h0000_a5c3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** src/chan_if.sv ***
// Purpose: Bundle between control core and stagger/detect unit
// Assumes: One clock domain
// Notes: Plain wires, no clocking block
`timescale 1ns/1ns
`default_nettype none
interface chan_if #(parameter int N = 16);
   logic [N-1:0] want_on;
   logic [N-1:0] sink_on;
   logic [N-1:0] low_volt;
   logic [N-1:0] open_led;
   modport core (output want_on, output low_volt, input sink_on,
      input open_led);
   modport unit (input want_on, input low_volt, output sink_on,
      output open_led);
endinterface
`default_nettype wire

// *** src/chan_stagger.sv ***
// Purpose: Per-channel switch delay and open-LED timing
// Assumes: Requests come from the same clock domain
// Notes: Step is a whole number of cycles
`timescale 1ns/1ns
`default_nettype none
module chan_stagger #(
   parameter int N = 16,
   parameter int STEP = 1,
   parameter int DETECT = 50
) (
   input wire logic aclk,
   input wire logic aresetn,
   chan_if.unit ch
);
   localparam int DW = $clog2(N * STEP + 2);
   localparam int TW = $clog2(DETECT + 2);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_ch
         logic [N*STEP:0] pipe_q;
         logic [TW-1:0] on_cnt_q;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pipe_q <= '0;
            end else begin
               pipe_q <= {pipe_q[N*STEP-1:0], ch.want_on[i]};
            end
         end
         if (i == 0) begin : g_z
            assign ch.sink_on[i] = ch.want_on[i];
         end else begin : g_d
            assign ch.sink_on[i] = pipe_q[i*STEP-1];
            stagger_step_a: assert property (@(posedge aclk) disable iff
               (!aresetn) ch.sink_on[i] == $past(ch.sink_on[i-1], STEP))
               else $error("stagger step wrong");
         end
         always_ff @(posedge aclk) begin
            if (!aresetn || !ch.sink_on[i]) begin
               on_cnt_q <= '0;
            end else if (on_cnt_q != TW'(DETECT)) begin
               on_cnt_q <= on_cnt_q + 1'b1;
            end
         end
         assign ch.open_led[i] = ch.sink_on[i] &&
            on_cnt_q == TW'(DETECT) && ch.low_volt[i];
      end
   endgenerate
   logic [DW-1:0] unused_w;
   assign unused_w = '0;
endmodule
`default_nettype wire

// *** src/led_sink_dot_correction_ctrl.sv ***
// Purpose: Serial load, latches, PWM gating and error flags of LED sink
// Assumes: Link pins are asynchronous; sampled by aclk (link 160 ns)
// Notes: Registers on AXI4-Lite hold a software overheat input and status
`timescale 1ns/1ns
`default_nettype none
module led_sink_dot_correction_ctrl #(
   parameter int N = led_sink_pkg::CHANNELS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic shift_clock,
   input wire logic serial_in,
   input wire logic latch_strobe,
   input wire logic mode,
   input wire logic output_disable,
   input wire logic pwm_count_clock,
   input wire logic [15:0] sink_low_volt,
   output logic serial_out,
   output logic error_out_n_o,
   output logic error_out_n_oe,
   output logic [15:0] sink_channel,
   output logic [95:0] dc_level,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int GL = led_sink_pkg::GS_LEN;
   localparam int DL = led_sink_pkg::DC_LEN;
   localparam int GB = led_sink_pkg::GS_BITS;
   localparam int DB = led_sink_pkg::DC_BITS;

   // Two-flop synchronisers for every pin
   logic [5:0] s1_q, s2_q, s3_q;
   logic [15:0] lv1_q, lv2_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lv1_q <= '0;
         lv2_q <= '0;
      end else begin
         s1_q <= {pwm_count_clock, output_disable, mode, latch_strobe,
            serial_in, shift_clock};
         s2_q <= s1_q;
         s3_q <= s2_q;
         lv1_q <= sink_low_volt;
         lv2_q <= lv1_q;
      end
   end
   logic sclk_rise, sdi, latch, latch_fall, mode_dc, dis, dis_rise;
   logic gclk_rise;
   assign sclk_rise = s2_q[0] && !s3_q[0];
   assign sdi = s2_q[1];
   assign latch = s2_q[2];
   assign latch_fall = !s2_q[2] && s3_q[2];
   assign mode_dc = s2_q[3];
   assign dis = s2_q[4];
   assign dis_rise = s2_q[4] && !s3_q[4];
   assign gclk_rise = s2_q[5] && !s3_q[5];

   // Software-driven overheat indication and status mirror
   logic overheat_in_q, overheat_flag;
   logic [N-1:0] open_led_flag;
   logic [N-1:0] open_cap_q;

   assign overheat_flag = overheat_in_q;

   // Shift register and status packet
   logic [GL-1:0] shreg_q;
   logic [GB*N-1:0] gs_q;
   logic [DB*N-1:0] dc_q;
   logic latch_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_q <= 1'b0;
      end else begin
         latch_q <= latch;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_cap_q <= '0;
      end else if (latch_fall) begin
         open_cap_q <= open_led_flag;
      end
   end
   logic [GL-1:0] status_info_packet;
   always_comb begin
      status_info_packet = '0;
      status_info_packet[N-1:0] = open_cap_q;
      status_info_packet[led_sink_pkg::SID_TEF_POS] = overheat_flag;
      status_info_packet[led_sink_pkg::SID_DC_LO +: DL] = dc_q;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shreg_q <= '0;
      end else if (latch_fall && !mode_dc) begin
         shreg_q <= status_info_packet;
      end else if (sclk_rise && !latch) begin
         if (mode_dc) begin
            shreg_q[DL-1:0] <= {shreg_q[DL-2:0], sdi};
         end else begin
            shreg_q <= {shreg_q[GL-2:0], sdi};
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_out <= 1'b0;
      end else begin
         serial_out <= mode_dc ? shreg_q[DL-1] : shreg_q[GL-1];
      end
   end
   always_ff @(posedge aclk) begin
      if (latch && !mode_dc && !latch_q) begin
         gs_q <= shreg_q;
      end
   end
   always_ff @(posedge aclk) begin
      if (latch && mode_dc) begin
         dc_q <= shreg_q[DL-1:0];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dc_level <= '0;
      end else begin
         dc_level <= dc_q;
      end
   end

   // Grayscale counter
   logic [GB-1:0] gcnt_q;
   logic run_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || dis) begin
         gcnt_q <= '0;
      end else if (gclk_rise && gcnt_q != {GB{1'b1}}) begin
         gcnt_q <= gcnt_q + 1'b1;
      end
   end
   // After a disable rise, sink_channel follows stagger until it has passed
   logic [4:0] hold_q;
   localparam int HOLD = led_sink_pkg::MAX_STAGGER_NS /
      led_sink_pkg::CLK_PERIOD_NS;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= 1'b0;
      end else begin
         run_q <= !dis;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_q <= '0;
      end else if (dis_rise) begin
         hold_q <= 5'(HOLD);
      end else if (hold_q != '0) begin
         hold_q <= hold_q - 1'b1;
      end
   end

   chan_if #(.N(N)) ch ();
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_req
         logic [GB-1:0] lvl;
         assign lvl = gs_q[i*GB +: GB];
         assign ch.want_on[i] = !dis && gcnt_q != '0 && gcnt_q <= lvl;
      end
   endgenerate
   assign ch.low_volt = lv2_q;
   chan_stagger #(
      .N(N),
      .STEP(led_sink_pkg::STEP_CYC),
      .DETECT(led_sink_pkg::OPEN_DETECT_CYC)
   ) u_stagger (
      .aclk(aclk),
      .aresetn(aresetn),
      .ch(ch)
   );
   // Hard off while disabled past stagger
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sink_channel <= '0;
      end else if (dis && hold_q == '0 && !dis_rise) begin
         sink_channel <= '0;
      end else begin
         sink_channel <= ch.sink_on;
      end
   end
   assign open_led_flag = ch.open_led;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         error_out_n_oe <= 1'b0;
      end else begin
         error_out_n_oe <= overheat_flag || (!dis && |open_led_flag);
      end
   end
   assign error_out_n_o = 1'b0;

   // AXI4-Lite slave
   logic [7:0] awa_q, ara_q;
   logic aw_have_q, w_have_q;
   logic [31:0] wd_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awa_q <= '0;
         wd_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= led_sink_pkg::RESP_OKAY;
         overheat_in_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awa_q <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wd_q <= s_axi_wdata;
         end
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awa_q == led_sink_pkg::REG_CTRL) begin
               s_axi_bresp <= led_sink_pkg::RESP_OKAY;
               overheat_in_q <= wd_q[0];
            end else begin
               s_axi_bresp <= led_sink_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      end
   end
   logic [31:0] rd;
   always_comb begin
      rd = '0;
      case (ara_q)
         led_sink_pkg::REG_CTRL: rd = {31'h0, overheat_in_q};
         led_sink_pkg::REG_STATUS: rd = {26'h0, mode_dc, dis, latch,
            !error_out_n_oe, 1'b0, overheat_flag};
         led_sink_pkg::REG_OPEN: rd = {16'h0, open_led_flag};
         led_sink_pkg::REG_GSCOUNT: rd = {20'h0, gcnt_q};
         led_sink_pkg::REG_ID: rd = led_sink_pkg::ID_VALUE;
         default: rd = '0;
      endcase
   end
   logic ar_have_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         ar_have_q <= 1'b0;
         ara_q <= '0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= led_sink_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !ar_have_q && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            ar_have_q <= 1'b1;
            ara_q <= s_axi_araddr[7:0];
         end
         if (ar_have_q && !s_axi_rvalid) begin
            ar_have_q <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd;
            s_axi_rresp <= (ara_q <= led_sink_pkg::REG_ID &&
               ara_q[1:0] == 2'b00) ? led_sink_pkg::RESP_OKAY :
               led_sink_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   overheat_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
      overheat_flag |=> error_out_n_oe) else $error("overheat no err");
   mask_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (dis && !overheat_flag) |=> !error_out_n_oe)
      else $error("open not masked");
   gs_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dis |=> gcnt_q == '0) else $error("count not cleared");
   sid_tef_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (latch_fall && !mode_dc) |=> shreg_q[16] == $past(overheat_flag))
      else $error("status tef wrong");
   dc_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (latch && mode_dc) |=> dc_q == $past(shreg_q[95:0]))
      else $error("dc not transparent");
   open_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      latch_fall |=> open_cap_q == $past(open_led_flag))
      else $error("open capture wrong");
   dis_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (dis && hold_q == '0 && !dis_rise) |=> sink_channel == '0)
      else $error("channel on while off");
   dc_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (sclk_rise && !latch && mode_dc && !latch_fall) |=>
      shreg_q[0] == $past(sdi) && shreg_q[191:96] == $past(shreg_q[191:96]))
      else $error("dc shift length");
endmodule
`default_nettype wire

// *** verification/host_link_model.sv ***
// Purpose: Host model driving the serial link pins
// Assumes: aclk 20 ns, link period 160 ns (4 cycles per phase)
// Notes: Pins change only after aclk rising edges
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
   input wire logic aclk,
   input wire logic serial_out,
   output logic shift_clock,
   output logic serial_in,
   output logic latch_strobe,
   output logic mode,
   output logic output_disable,
   output logic pwm_count_clock
);
   initial begin
      shift_clock = 1'b0;
      serial_in = 1'b0;
      latch_strobe = 1'b0;
      mode = 1'b0;
      output_disable = 1'b1;
      pwm_count_clock = 1'b0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // MSB first; far end sampled before each rise
   task automatic shift_bits(input logic [191:0] d, input int n,
      output logic [191:0] seen);
      seen = '0;
      for (int k = n - 1; k >= 0; k--) begin
         serial_in <= d[k];
         wait_cyc(4);
         seen[k] = serial_out;
         shift_clock <= 1'b1;
         wait_cyc(4);
         shift_clock <= 1'b0;
      end
   endtask
   // pulse only with shift clock idle
   task automatic pulse_latch();
      wait_cyc(4);
      latch_strobe <= 1'b1;
      wait_cyc(4);
      latch_strobe <= 1'b0;
      wait_cyc(8);
   endtask
   // mode changes only while latch is low
   task automatic set_mode(input logic m);
      wait_cyc(1);
      mode <= m;
      wait_cyc(4);
   endtask
   task automatic set_disable(input logic v);
      wait_cyc(1);
      output_disable <= v;
   endtask
   task automatic pulse_pwm();
      wait_cyc(4);
      pwm_count_clock <= 1'b1;
      wait_cyc(4);
      pwm_count_clock <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** verification/led_sink_dot_correction_ctrl_tb.sv ***
// Purpose: Self-checking bench of the LED sink control block
// Assumes: 50 MHz aclk; host model runs the link pins
// Notes: Error line resolved with a pull-up in the bench
`timescale 1ns/1ns
`default_nettype none
module led_sink_dot_correction_ctrl_tb;
   localparam int STEP = led_sink_pkg::STEP_CYC;
   localparam logic [95:0] DC_A = 96'h0123456789abcdeffedcba98;
   localparam logic [95:0] DC_B = 96'hfc0f3c5a6996a5c30ff01e2d;
   localparam logic [191:0] GS_ON = {192{1'b1}};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [15:0] sink_low_volt = 16'h0000;
   logic shift_clock, serial_in, latch_strobe, mode, output_disable;
   logic pwm_count_clock, serial_out, error_out_n_o, error_out_n_oe;
   logic error_line;
   logic [15:0] sink_channel;
   logic [15:0] prev_sink = 16'h0000;
   logic [95:0] dc_level;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int on_t [16];
   int off_t [16];
   assign error_line = error_out_n_oe ? error_out_n_o : 1'b1;
   initial begin
      forever #10 aclk = ~aclk;
   end
   led_sink_dot_correction_ctrl dut_u (.aclk(aclk), .aresetn(aresetn),
      .shift_clock(shift_clock), .serial_in(serial_in),
      .latch_strobe(latch_strobe), .mode(mode),
      .output_disable(output_disable), .pwm_count_clock(pwm_count_clock),
      .sink_low_volt(sink_low_volt), .serial_out(serial_out),
      .error_out_n_o(error_out_n_o), .error_out_n_oe(error_out_n_oe),
      .sink_channel(sink_channel), .dc_level(dc_level),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   host_link_model host_u (.aclk(aclk), .serial_out(serial_out),
      .shift_clock(shift_clock), .serial_in(serial_in),
      .latch_strobe(latch_strobe), .mode(mode),
      .output_disable(output_disable), .pwm_count_clock(pwm_count_clock));
   task automatic test_done();
      $display("num_errors=%0d tests_run=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [191:0] seen, input logic [191:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Switch edge times per channel; limit cuts a hang short
   always @(posedge aclk) begin
      cyc = cyc + 1;
      for (int k = 0; k < 16; k++) begin
         if (sink_channel[k] === 1'b1 && prev_sink[k] === 1'b0) on_t[k] = cyc;
         if (sink_channel[k] === 1'b0 && prev_sink[k] === 1'b1) off_t[k] = cyc;
      end
      prev_sink = sink_channel;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   initial begin
      logic [191:0] seen;
      logic [31:0] rd;
      logic [1:0] rr;
      int n;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      sink_low_volt <= 16'h0005;
      axi_read({24'h0, led_sink_pkg::REG_ID}, rd, rr);
      check(rd, led_sink_pkg::ID_VALUE);
      axi_read(32'h0000_0020, rd, rr);
      check(rr, led_sink_pkg::RESP_SLVERR);
      axi_write({24'h0, led_sink_pkg::REG_CTRL}, 32'h1);
      host_u.wait_cyc(4);
      check(error_line, 1'b0);
      axi_read({24'h0, led_sink_pkg::REG_STATUS}, rd, rr);
      check(rd[0], 1'b1);
      axi_write({24'h0, led_sink_pkg::REG_CTRL}, 32'h0);
      host_u.wait_cyc(4);
      check(error_line, 1'b1);
      host_u.shift_bits(GS_ON, 192, seen);
      host_u.pulse_latch();
      host_u.set_mode(1'b1);
      host_u.shift_bits({96'h0, DC_A}, 96, seen);
      host_u.pulse_latch();
      check(dc_level, DC_A);
      host_u.shift_bits({96'h0, DC_B}, 96, seen);
      check(seen[95:0], DC_A);
      check(dc_level, DC_A);
      host_u.set_disable(1'b0);
      host_u.pulse_pwm();
      n = 0;
      while (sink_channel[0] !== 1'b1 && n < 200) begin
         @(posedge aclk);
         n++;
      end
      host_u.wait_cyc(40);
      check(error_line, 1'b1);
      host_u.wait_cyc(30);
      check(error_line, 1'b0);
      check(sink_channel, 16'hffff);
      host_u.pulse_latch();
      check(dc_level, DC_B);
      host_u.set_mode(1'b0);
      host_u.shift_bits(GS_ON, 192, seen);
      axi_write({24'h0, led_sink_pkg::REG_CTRL}, 32'h1);
      host_u.pulse_latch();
      host_u.set_disable(1'b1);
      host_u.wait_cyc(30);
      check(sink_channel, 16'h0000);
      for (int k = 1; k < 16; k++) begin
         check(192'(on_t[k] - on_t[0]), 192'(k * STEP));
         check(192'(off_t[k] - off_t[0]), 192'(k * STEP));
      end
      axi_read({24'h0, led_sink_pkg::REG_GSCOUNT}, rd, rr);
      check(rd, 32'h0);
      check(error_line, 1'b0);
      axi_write({24'h0, led_sink_pkg::REG_CTRL}, 32'h0);
      host_u.wait_cyc(4);
      check(error_line, 1'b1);
      host_u.shift_bits(192'h0, 192, seen);
      check(seen[15:0], 16'h0005);
      check(seen[16], 1'b1);
      check(seen[119:24], DC_B);
      test_done();
   end
endmodule
`default_nettype wire
